/* File: core/pbg_map.vh */
// Register map, reset values and pin positions of the port B block.
// Functional notes
// RULE1: PWM enables drive pins 0 and 1.
// RULE2: Software sets direction for overridden pins 0-3.
// RULE3: Crystal clock on pin 3 when selected and running.
// RULE4: Core clock drives pin 2 when selected.
// RULE5: Sync serial on makes pins 5,4 open-drain.
// RULE6: Pins 4,5 follow sync serial line values.
// RULE7: Software enables pull-ups for sync serial pins.
// RULE8: Transmit enable makes pin 6 transmit output.
// RULE9: Receive enable makes pin 7 receive input.
// RULE10: Direction one enables output buffer, zero tristates.
// RULE11: Reset clears all direction bits.
// RULE12: Input register shows raw pin levels.
// RULE13: Input buffer stays active on outputs.
// RULE14: Output register drives outputs, resets zero.
// RULE15: Open-drain drives low only, resets push-pull.
// RULE16: Pull-up select bits, reset zero.
// RULE17: Pull-up only on inputs or released open-drain.
// RULE18: Input buffer on except in analog mode.
// RULE19: Analog beats function beats digital I/O.
// RULE20: Four analog bits each cover a pin pair.
// RULE21: Registers update on clock, reset asynchronously.
`ifndef PBG_MAP_VH
`define PBG_MAP_VH
// ***************************************************************
// Register byte addresses
// ***************************************************************
`define PBG_ADDR_IN 6'h00
`define PBG_ADDR_OUT 6'h04
`define PBG_ADDR_DIR 6'h08
`define PBG_ADDR_OPEN 6'h0C
`define PBG_ADDR_PULLUP 6'h10
`define PBG_ADDR_ANA 6'h14
`define PBG_ADDR_FUNC 6'h18
`define PBG_ADDR_SERIAL 6'h1C
// ***************************************************************
// Reset values and field positions
// ***************************************************************
`define PBG_RST_BYTE 8'h00
`define PBG_RST_ANA 4'h0
`define PBG_RST_FUNC 7'h00
`define PBG_RST_SERIAL 2'h0
`define PBG_F_PWM0 0
`define PBG_F_PWM1 1
`define PBG_F_XCK 2
`define PBG_F_XON 3
`define PBG_F_CCK 4
`define PBG_F_SYNC 5
`define PBG_F_CSEL 6
`define PBG_S_L0 0
`define PBG_S_L1 1
`define PBG_P_PWM0 0
`define PBG_P_PWM1 1
`define PBG_P_CCK 2
`define PBG_P_XCK 3
`define PBG_P_S0 4
`define PBG_P_S1 5
`define PBG_P_TX 6
`define PBG_P_RX 7
`define PBG_HTRANS_NONSEQ 2'h2
`endif

/* File: core/pbg_sync2.v */
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/1ps
module pbg_sync2 #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // pbg_sync2

/* File: core/pbg_port.v */
// Port B GPIO with peripheral function override and AHB-Lite registers.
`timescale 1ns/1ps
`include "pbg_map.vh"
module pbg_port #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Peripheral sources
   input wire pwm0_wave,
   input wire pwm1_wave,
   input wire crystal_clock,
   input wire core_clock,
   input wire sync_serial_line0_out_en,
   input wire sync_serial_line1_out_en,
   input wire async_serial_transmit_on,
   input wire async_serial_receive_on,
   input wire async_serial_tx_data,
   output reg async_serial_rx_data,
   output reg sync_serial_line0_in,
   output reg sync_serial_line1_in,
   // Pins
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_out,
   output reg [WIDTH-1:0] pin_oe,
   output reg [WIDTH-1:0] pin_pullup_en,
   output reg [WIDTH-1:0] pin_input_buf_en,
   output reg [WIDTH-1:0] pin_analog_en
);
   reg [WIDTH-1:0] pin_output_value_q;
   reg [WIDTH-1:0] pin_direction_q;
   reg [WIDTH-1:0] pin_open_drain_select_q;
   reg [WIDTH-1:0] pin_pullup_select_q;
   reg [3:0] pin_pair_analog_select_q;
   reg [6:0] func_q;
   reg [1:0] serial_q;
   reg wr_pend_q;
   reg [5:0] wr_addr_q;
   wire [WIDTH-1:0] pin_input_value;
   wire crystal_clock_sync;
   wire counter_pulse_out0_en = func_q[`PBG_F_PWM0];
   wire counter_pulse_out1_en = func_q[`PBG_F_PWM1];
   wire crystal_clock_pin_out_en = func_q[`PBG_F_XCK];
   wire crystal_osc_on = func_q[`PBG_F_XON];
   wire core_clock_pin_out_en = func_q[`PBG_F_CCK];
   wire sync_serial_on = func_q[`PBG_F_SYNC];
   wire sync_serial_line0_value = serial_q[`PBG_S_L0];
   wire sync_serial_line1_value = serial_q[`PBG_S_L1];

   // ***************************************************************
   // Pin input synchroniser
   // ***************************************************************
   // Pins are asynchronous, so the read path sees them two cycles late.
   pbg_sync2 #(.WIDTH(WIDTH)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(pin_in),
      .sync_out(pin_input_value)
   ); // RULE12

   // The crystal runs from its own oscillator, so it is retimed before it reaches a pin.
   pbg_sync2 #(.WIDTH(1)) u_xtal_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(crystal_clock),
      .sync_out(crystal_clock_sync)
   ); // RULE3

   // ***************************************************************
   // AHB-Lite register access
   // ***************************************************************
   wire take = hsel && hready && htrans == `PBG_HTRANS_NONSEQ;

   function [31:0] rd_mux;
      input [5:0] a;
      begin
         case (a)
            `PBG_ADDR_IN: rd_mux = {24'h000000, pin_input_value}; // RULE12 RULE13
            `PBG_ADDR_OUT: rd_mux = {24'h000000, pin_output_value_q};
            `PBG_ADDR_DIR: rd_mux = {24'h000000, pin_direction_q};
            `PBG_ADDR_OPEN: rd_mux = {24'h000000, pin_open_drain_select_q};
            `PBG_ADDR_PULLUP: rd_mux = {24'h000000, pin_pullup_select_q};
            `PBG_ADDR_ANA: rd_mux = {28'h0000000, pin_pair_analog_select_q};
            `PBG_ADDR_FUNC: rd_mux = {25'h0, func_q};
            `PBG_ADDR_SERIAL: rd_mux = {30'h0, serial_q};
            default: rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 6'h00;
      end else begin
         wr_pend_q <= take && hwrite;
         if (take) begin
            wr_addr_q <= haddr[5:0];
         end
         if (take && !hwrite) begin
            hrdata <= haddr[31:6] == 26'h0 ? rd_mux(haddr[5:0]) : 32'h00000000;
         end
      end
   end

   // Writes land at the end of the data phase.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_output_value_q <= `PBG_RST_BYTE; // RULE14 RULE21
         pin_direction_q <= `PBG_RST_BYTE; // RULE11
         pin_open_drain_select_q <= `PBG_RST_BYTE; // RULE15
         pin_pullup_select_q <= `PBG_RST_BYTE; // RULE16
         pin_pair_analog_select_q <= `PBG_RST_ANA; // RULE20
         func_q <= `PBG_RST_FUNC;
         serial_q <= `PBG_RST_SERIAL;
      end else if (wr_pend_q) begin
         case (wr_addr_q) // RULE21
            `PBG_ADDR_OUT: pin_output_value_q <= hwdata[WIDTH-1:0];
            `PBG_ADDR_DIR: pin_direction_q <= hwdata[WIDTH-1:0];
            `PBG_ADDR_OPEN: pin_open_drain_select_q <= hwdata[WIDTH-1:0];
            `PBG_ADDR_PULLUP: pin_pullup_select_q <= hwdata[WIDTH-1:0];
            `PBG_ADDR_ANA: pin_pair_analog_select_q <= hwdata[3:0]; // RULE20
            `PBG_ADDR_FUNC: func_q <= hwdata[6:0];
            `PBG_ADDR_SERIAL: serial_q <= hwdata[1:0];
            default: serial_q <= serial_q;
         endcase
      end
   end

   // ***************************************************************
   // Pin control resolution
   // ***************************************************************
   reg [WIDTH-1:0] val_d;
   reg [WIDTH-1:0] dir_d;
   reg [WIDTH-1:0] od_d;
   reg [WIDTH-1:0] ana_d;
   reg [WIDTH-1:0] oe_d;
   reg [WIDTH-1:0] pu_d;
   reg [WIDTH-1:0] drv_d;
   integer i;
   always @* begin
      val_d = pin_output_value_q;
      dir_d = pin_direction_q;
      od_d = pin_open_drain_select_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
         ana_d[i] = pin_pair_analog_select_q[i/2]; // RULE20
      end
      // Direction on pins 0 to 3 stays with software even when overridden.
      if (counter_pulse_out0_en) val_d[`PBG_P_PWM0] = pwm0_wave; // RULE1 RULE2
      if (counter_pulse_out1_en) val_d[`PBG_P_PWM1] = pwm1_wave; // RULE1
      if (core_clock_pin_out_en) val_d[`PBG_P_CCK] = core_clock; // RULE4
      if (crystal_clock_pin_out_en && crystal_osc_on) val_d[`PBG_P_XCK] = crystal_clock_sync; // RULE3
      if (sync_serial_on) begin // RULE5 RULE6
         od_d[`PBG_P_S0] = 1'b1;
         od_d[`PBG_P_S1] = 1'b1;
         dir_d[`PBG_P_S0] = sync_serial_line0_out_en;
         dir_d[`PBG_P_S1] = sync_serial_line1_out_en;
         val_d[`PBG_P_S0] = sync_serial_line0_value;
         val_d[`PBG_P_S1] = sync_serial_line1_value;
      end
      if (async_serial_transmit_on) begin // RULE8
         dir_d[`PBG_P_TX] = 1'b1;
         val_d[`PBG_P_TX] = async_serial_tx_data;
      end
      if (async_serial_receive_on) begin // RULE9
         dir_d[`PBG_P_RX] = 1'b0;
         val_d[`PBG_P_RX] = 1'b0;
      end
      for (i = 0; i < WIDTH; i = i + 1) begin
         // Open-drain drives only the low level.
         drv_d[i] = od_d[i] ? 1'b0 : val_d[i]; // RULE15
         oe_d[i] = !ana_d[i] && dir_d[i] && !(od_d[i] && val_d[i]); // RULE10 RULE19
         // Pull-ups idle on driven pins to save power.
         pu_d[i] = !ana_d[i] && pin_pullup_select_q[i] && (!dir_d[i] || (od_d[i] && val_d[i])); // RULE17
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= `PBG_RST_BYTE;
         pin_oe <= `PBG_RST_BYTE;
         pin_pullup_en <= `PBG_RST_BYTE;
         pin_input_buf_en <= ~`PBG_RST_BYTE;
         pin_analog_en <= `PBG_RST_BYTE;
         async_serial_rx_data <= 1'b1;
         sync_serial_line0_in <= 1'b1;
         sync_serial_line1_in <= 1'b1;
      end else begin
         pin_out <= drv_d;
         pin_oe <= oe_d;
         pin_pullup_en <= pu_d;
         pin_input_buf_en <= ~ana_d; // RULE13 RULE18 RULE19
         pin_analog_en <= ana_d; // RULE19
         async_serial_rx_data <= pin_input_value[`PBG_P_RX]; // RULE9
         sync_serial_line0_in <= pin_input_value[`PBG_P_S0];
         sync_serial_line1_in <= pin_input_value[`PBG_P_S1];
      end
   end
endmodule // pbg_port

/* File: test/pbg_monitor.sv */
// Checker of the port B pin and bus behaviour.
`timescale 1ns/1ps
module pbg_monitor #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Watched ports
   input wire hreadyout,
   input wire hresp,
   input wire async_serial_transmit_on,
   input wire async_serial_receive_on,
   input wire async_serial_tx_data,
   input wire async_serial_rx_data,
   input wire [WIDTH-1:0] pin_in,
   input wire [WIDTH-1:0] pin_out,
   input wire [WIDTH-1:0] pin_oe,
   input wire [WIDTH-1:0] pin_pullup_en,
   input wire [WIDTH-1:0] pin_input_buf_en,
   input wire [WIDTH-1:0] pin_analog_en
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_always_okay: assert property (hreadyout && !hresp) else $error("bus stalled");
   a_reset_inputs: assert property ($rose(hresetn) |-> pin_oe == 0 && pin_pullup_en == 0) else $error("reset");
   a_analog_no_drive: assert property ((pin_oe & pin_analog_en) == 0) else $error("analog driven");
   a_input_buf_on: assert property (pin_input_buf_en == ~pin_analog_en) else $error("input buffer");
   a_pullup_gated: assert property ((pin_pullup_en & (pin_oe | pin_analog_en)) == 0) else $error("pullup");
   a_rx_pin_input: assert property ($past(async_serial_receive_on) |-> !pin_oe[7]) else $error("rx pin");
   a_tx_pin_drive: assert property ($past(hresetn) && $past(async_serial_transmit_on) && !pin_analog_en[6] |->
      pin_oe[6] && pin_out[6] == $past(async_serial_tx_data)) else $error("tx pin");
   a_rx_raw_level: assert property ($past(hresetn, 3) |-> async_serial_rx_data == $past(pin_in[7], 3))
      else $error("rx level");
   c_tx: cover property (pin_oe[6]);
   c_pullup: cover property (pin_pullup_en[4]);
   c_analog: cover property (pin_analog_en[0]);
endmodule // pbg_monitor
bind pbg_port pbg_monitor #(.WIDTH(WIDTH)) mon_u (.hclk, .hresetn, .hreadyout, .hresp, .async_serial_transmit_on,
   .async_serial_receive_on, .async_serial_tx_data, .async_serial_rx_data, .pin_in, .pin_out, .pin_oe,
   .pin_pullup_en, .pin_input_buf_en, .pin_analog_en);

/* File: test/pbg_board.sv */
// Board model that resolves each pin level from drive, pull-up and idle state.
`timescale 1ns/1ps
module pbg_board (
   input wire hclk,
   input wire [7:0] pin_out,
   input wire [7:0] pin_oe,
   input wire [7:0] pin_pullup_en,
   output logic [7:0] pin_level
);
   logic [7:0] float_q = 8'h5A;
   // A floating pin flips each cycle, so a stale level never passes for a drive.
   always @(posedge hclk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      pin_level = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | float_q));
   end
endmodule // pbg_board

/* File: test/pbg_port_test.sv */
// Self-checking testbench of the port B block.
`timescale 1ns/1ps
module pbg_port_test;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic pwm0_wave = 1, pwm1_wave = 0, crystal_clock = 1, core_clock = 1, async_serial_tx_data = 1;
   logic sync_serial_line0_out_en = 1, sync_serial_line1_out_en = 1;
   logic async_serial_transmit_on = 0, async_serial_receive_on = 0;
   logic async_serial_rx_data, sync_serial_line0_in, sync_serial_line1_in;
   logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_input_buf_en, pin_analog_en;
   int failures = 0, checked = 0;
   always #25 hclk = ~hclk;
   pbg_port #(.WIDTH(8)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .pwm0_wave, .pwm1_wave, .crystal_clock, .core_clock, .sync_serial_line0_out_en,
      .sync_serial_line1_out_en, .async_serial_transmit_on, .async_serial_receive_on, .async_serial_tx_data,
      .async_serial_rx_data, .sync_serial_line0_in, .sync_serial_line1_in, .pin_in, .pin_out, .pin_oe,
      .pin_pullup_en, .pin_input_buf_en, .pin_analog_en);
   pbg_board board_u (.hclk, .pin_out, .pin_oe, .pin_pullup_en, .pin_level(pin_in));
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic settle;
      repeat (6) @(posedge hclk);
   endtask
   task automatic t_reset;
      for (int a = 4; a < 32; a += 4) begin
         xfer(1'b0, 32'(a), 32'h0);
         chk(rd, 32'h0);
      end
      chk(32'(pin_oe), 32'h0);
   endtask
   task automatic t_digital;
      xfer(1'b1, 32'h08, 32'hFF);
      xfer(1'b1, 32'h04, 32'hA5);
      settle;
      chk(32'(pin_oe), 32'hFF);
      chk(32'(pin_out), 32'hA5);
      xfer(1'b0, 32'h00, 32'h0);
      chk(rd, 32'hA5);
      xfer(1'b1, 32'h0C, 32'h0F);
      xfer(1'b1, 32'h10, 32'hFF);
      settle;
      chk(32'(pin_oe), 32'hFA);
      chk(32'(pin_pullup_en), 32'h05);
      xfer(1'b0, 32'h00, 32'h0);
      chk(rd, 32'hA5);
   endtask
   task automatic t_func;
      xfer(1'b1, 32'h0C, 32'h0);
      xfer(1'b1, 32'h10, 32'h30);
      xfer(1'b1, 32'h04, 32'hF2);
      xfer(1'b1, 32'h18, 32'h1F);
      settle;
      chk(32'(pin_out[3:0]), 32'hD);
      xfer(1'b1, 32'h18, 32'h17);
      settle;
      chk(32'(pin_out[3:0]), 32'h5);
      xfer(1'b1, 32'h1C, 32'h1);
      xfer(1'b1, 32'h08, 32'h8F);
      xfer(1'b1, 32'h18, 32'h60);
      async_serial_tx_data <= 1'b0;
      async_serial_transmit_on <= 1'b1;
      async_serial_receive_on <= 1'b1;
      settle;
      chk(32'(pin_oe[7:4]), 32'h6);
      chk(32'(pin_out[6:5]), 32'h0);
      chk(32'(pin_pullup_en), 32'h10);
      chk(32'(sync_serial_line0_in), 32'h1);
      chk(32'(sync_serial_line1_in), 32'h0);
   endtask
   task automatic t_analog;
      sync_serial_line1_out_en <= 1'b0;
      xfer(1'b1, 32'h14, 32'h9);
      xfer(1'b1, 32'h20, 32'hFF);
      settle;
      chk(32'(pin_analog_en), 32'hC3);
      chk(32'(pin_input_buf_en), 32'h3C);
      chk(32'(pin_oe & 8'hC3), 32'h0);
      chk(32'(pin_oe[5:4]), 32'h0);
      chk(32'(pin_pullup_en[5:4]), 32'h3);
      xfer(1'b0, 32'h20, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, 32'h14, 32'h0);
      chk(rd, 32'h9);
      xfer(1'b0, 32'h18, 32'h0);
      chk(rd, 32'h60);
   endtask
   task automatic t_again;
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk(32'(pin_oe), 32'h0);
      chk(32'(pin_analog_en), 32'h0);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, 32'h08, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, 32'h18, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic final_report;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_digital;
      t_func;
      t_analog;
      t_again;
      final_report;
   end
   // The run needs about 130 cycles; the margin only catches a hung handshake.
   initial begin
      repeat (3000) @(posedge hclk);
      failures++;
      final_report;
   end
endmodule // pbg_port_test
